// ### rtl/sif_debounce.sv
`timescale 1ns/10ps
module sif_debounce
(
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     resetn,
   // raw level and chosen delay
   input  wire logic                     raw,
   input  wire logic [sif_pkg::DEB_W-1:0] delay_cyc,
   // filtered level
   output logic                          level
);
   logic [sif_pkg::DEB_W-1:0] cnt;

   // new level taken only once stable for the whole delay
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt   <= '0;
         level <= 1'b0;
      end
      else if (raw == level)
      begin
         cnt <= '0;
      end
      else if (cnt >= delay_cyc - 1'b1)
      begin
         cnt   <= '0;
         level <= raw;
      end
      else
      begin
         cnt <= cnt + 1'b1;
      end
   end
endmodule : sif_debounce

// ### rtl/sif_frontend.sv
`timescale 1ns/10ps
// Summary of operation
// - rts raised while message pending, handshake on
// - with RS232 handshake on, data sent only while cts asserted
// - reset selects RS232 main port mode
// - RS232 carries code data and commands
// - full duplex transmits without poll
// - polled protocol forces half duplex
// - slave answers only polls addressed to it
// - multidrop address held, written by software
// - aux port RS232 only, active when enabled
// - aux port config, echo or pass-through
// - four inputs, per-input active level
// - debounce delay 5 ms or 500 us
// - trigger and generics share one setting
// - encoder follows up to 1 kHz
// - online trigger starts scanning
// - phase lamp follows current, not active level
// - generic input ends reading phase
module sif_frontend
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // message source, serial data from the core uart
   input  wire logic        msg_pending,
   input  wire logic        msg_txd,
   input  wire logic        poll_seen,
   input  wire logic [7:0]  poll_addr,
   output logic             msg_grant,
   // main port pins
   input  wire logic        main_rxd,
   input  wire logic        main_cts,
   output logic             main_txd,
   output logic             main_rts,
   output logic             halfduplex_drv_en,
   output logic             main_rx_to_core,
   // aux port pins
   input  wire logic        aux_rxd,
   input  wire logic        aux_core_txd,
   output logic             aux_txd,
   output logic             aux_rx_to_core,
   // optocoupled inputs, high means current flows
   input  wire logic        scan_trigger_input,
   input  wire logic        conveyor_encoder_input,
   input  wire logic        generic_input_a,
   input  wire logic        generic_input_b,
   // control outputs
   output logic             scan_start,
   output logic             phase_end,
   output logic             phase_led
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0]              port_ctrl;
   logic [7:0]              md_addr;
   logic [6:0]              in_ctrl;
   logic [31:0]             enc_count;
   logic [3:0]              deb_lvl;
   logic [3:0]              act;
   logic [3:0]              act_d;
   logic [3:0]              raw_in;
   sif_pkg::sif_mode_t      eff_mode;
   sif_pkg::sif_tx_state_t  tx_state;
   sif_pkg::sif_main_tx_t   next_main;
   logic                    poll_ok;
   logic                    may_send;
   logic                    wr_en;

   // writes land at the access edge only, never in setup
   assign wr_en = psel & penable & pwrite;

   // mode 2'b10 alone is not decoded; half duplex comes with polling
   // polled protocol overrides the mode field
   always_comb
   begin
      if (port_ctrl[sif_pkg::PC_POLLED])
         eff_mode = sif_pkg::SIF_MODE_485_HD;
      else if (port_ctrl[sif_pkg::PC_MODE_LSB +: 2] == 2'b01)
         eff_mode = sif_pkg::SIF_MODE_485_FD;
      else
         eff_mode = sif_pkg::SIF_MODE_RS232;
   end

   ////////////////////////////////////////////////////////////////////////////
   // port control; reset gives RS232, no handshake
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         port_ctrl <= sif_pkg::PORT_CTRL_RST;
      else if (wr_en && paddr == sif_pkg::OFS_PORT_CTRL)
         port_ctrl <= pwdata[7:0];
   end

   // multidrop address, set by software through an apb write
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         md_addr <= sif_pkg::MD_ADDR_RST;
      else if (wr_en && paddr == sif_pkg::OFS_MD_ADDR)
         md_addr <= pwdata[7:0];
   end

   // input control; stop function enabled out of reset
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         in_ctrl <= sif_pkg::IN_CTRL_RST;
      else if (wr_en && paddr == sif_pkg::OFS_IN_CTRL)
         in_ctrl <= pwdata[6:0];
   end

   // zero-wait apb answer; unmapped reads zero with error
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         // read data latched in setup, so it stands in the access cycle
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel & ~penable)
         begin
            case (paddr)
               sif_pkg::OFS_PORT_CTRL: prdata <= {24'h000000, port_ctrl};
               sif_pkg::OFS_MD_ADDR:   prdata <= {24'h000000, md_addr};
               sif_pkg::OFS_IN_CTRL:   prdata <= {25'h0000000, in_ctrl};
               sif_pkg::OFS_STATUS:    prdata <= {24'h000000, 2'b00, tx_state,
                                                  deb_lvl};
               sif_pkg::OFS_ENC_COUNT: prdata <= enc_count;
               default:                pslverr <= 1'b1;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit permission per main-port mode
   assign poll_ok = poll_seen & (poll_addr == md_addr);

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         tx_state <= sif_pkg::SIF_TX_IDLE;
      else
      begin
         case (tx_state)
            // half duplex waits for a poll carrying our address
            sif_pkg::SIF_TX_IDLE:
               if (msg_pending)
               begin
                  if (eff_mode == sif_pkg::SIF_MODE_485_HD)
                  begin
                     if (poll_ok)
                        tx_state <= sif_pkg::SIF_TX_SEND;
                  end
                  else if (eff_mode == sif_pkg::SIF_MODE_485_FD)
                     tx_state <= sif_pkg::SIF_TX_SEND;
                  else if (port_ctrl[sif_pkg::PC_HS_EN])
                     tx_state <= sif_pkg::SIF_TX_REQ;
                  else
                     tx_state <= sif_pkg::SIF_TX_SEND;
               end
            // rts is up; hold until the host clears us
            sif_pkg::SIF_TX_REQ:
               if (!msg_pending)
                  tx_state <= sif_pkg::SIF_TX_IDLE;
               else if (main_cts)
                  tx_state <= sif_pkg::SIF_TX_SEND;
            // cts lost mid-message falls back to request
            sif_pkg::SIF_TX_SEND:
               if (!msg_pending)
                  tx_state <= sif_pkg::SIF_TX_IDLE;
               else if (eff_mode == sif_pkg::SIF_MODE_RS232 &&
                        port_ctrl[sif_pkg::PC_HS_EN] && !main_cts)
                  tx_state <= sif_pkg::SIF_TX_REQ;
            default:
               tx_state <= sif_pkg::SIF_TX_IDLE;
         endcase
      end
   end

   // sending allowed in send state, cts rechecked every cycle
   assign may_send = (tx_state == sif_pkg::SIF_TX_SEND) &&
                     !(eff_mode == sif_pkg::SIF_MODE_RS232 &&
                       port_ctrl[sif_pkg::PC_HS_EN] && !main_cts);

   // main-port pin values; line idles at mark
   always_comb
   begin
      next_main.txd    = may_send ? msg_txd : 1'b1;
      next_main.rts    = 1'b0;
      next_main.drv_en = 1'b0;
      if (eff_mode == sif_pkg::SIF_MODE_RS232 && port_ctrl[sif_pkg::PC_HS_EN])
         next_main.rts = msg_pending;
      if (eff_mode == sif_pkg::SIF_MODE_485_HD)
         next_main.drv_en = may_send;
      else
         next_main.drv_en = 1'b1;
   end

   // registered pins cost a cycle of latency, harmless at uart rates
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         main_txd          <= 1'b1;
         main_rts          <= 1'b0;
         halfduplex_drv_en <= 1'b0;
         main_rx_to_core   <= 1'b1;
         msg_grant         <= 1'b0;
      end
      else
      begin
         main_txd          <= next_main.txd;
         main_rts          <= next_main.rts;
         halfduplex_drv_en <= next_main.drv_en;
         // host line reaches the core uart one flop late
         main_rx_to_core   <= main_rxd;
         msg_grant         <= may_send;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // aux port: silent when disabled, else echo, pass or own data
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         aux_txd        <= 1'b1;
         aux_rx_to_core <= 1'b1;
      end
      else if (!port_ctrl[sif_pkg::PC_AUX_EN])
      begin
         aux_txd        <= 1'b1;
         aux_rx_to_core <= 1'b1;
      end
      else
      begin
         aux_rx_to_core <= aux_rxd;
         // echo takes the unregistered main bit so both pins move together
         if (port_ctrl[sif_pkg::PC_AUX_ECHO])
            aux_txd <= next_main.txd;
         else if (port_ctrl[sif_pkg::PC_AUX_PASS])
            aux_txd <= main_rxd;
         else
            aux_txd <= aux_core_txd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // four input channels, shared setting except encoder
   // bit order follows the input index constants
   assign raw_in = {generic_input_b, generic_input_a,
                    conveyor_encoder_input, scan_trigger_input};

   genvar gi;
   generate
      for (gi = 0; gi < sif_pkg::NUM_IN; gi++)
      begin : g_in
         logic [sif_pkg::DEB_W-1:0] dly;
         logic                      fast;
         // encoder defaults to 500 us so 1 kHz pulses survive
         assign fast = (gi == sif_pkg::IN_ENC) ? !in_ctrl[sif_pkg::IC_ENC_SLOW]
                       : in_ctrl[sif_pkg::IC_SHARED_FAST];
         assign dly  = fast ? sif_pkg::DEB_W'(sif_pkg::FAST_DEB_CYC)
                       : sif_pkg::DEB_W'(sif_pkg::SLOW_DEB_CYC);
         sif_debounce u_deb
         (
            .mclk      (mclk),
            .resetn    (resetn),
            .raw       (raw_in[gi]),
            .delay_cyc (dly),
            .level     (deb_lvl[gi])
         );
         // polarity bit set means active open
         assign act[gi] = deb_lvl[gi] ^ in_ctrl[sif_pkg::IC_POL_LSB + gi];
      end
   endgenerate

   // edge memory and encoder pulse counter
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         act_d     <= 4'h0;
         enc_count <= 32'h0000_0000;
      end
      else
      begin
         act_d <= act;
         // free-running; speed logic reads differences per window
         if (act[sif_pkg::IN_ENC] && !act_d[sif_pkg::IN_ENC])
            enc_count <= enc_count + 32'h0000_0001;
      end
   end

   // trigger starts a scan only in on-line mode
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         scan_start <= 1'b0;
      else
         scan_start <= port_ctrl[sif_pkg::PC_ONLINE] &&
                       act[sif_pkg::IN_TRIG] && !act_d[sif_pkg::IN_TRIG];
   end

   // either generic input ends the phase when the one shared stop enable bit is set
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         phase_end <= 1'b0;
      else
         phase_end <= in_ctrl[sif_pkg::IC_STOP_EN] &&
                      ((act[sif_pkg::IN_GEN_A] && !act_d[sif_pkg::IN_GEN_A]) ||
                       (act[sif_pkg::IN_GEN_B] && !act_d[sif_pkg::IN_GEN_B]));
   end

   // lamp shows trigger loop current, so an active-open trigger lights it when idle
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         phase_led <= 1'b0;
      else
         phase_led <= deb_lvl[sif_pkg::IN_TRIG];
   end
endmodule : sif_frontend

// ### rtl/sif_pkg.sv
package sif_pkg;
   // clock and debounce timing
   localparam int unsigned CLK_HZ          = 40000000;
   localparam int unsigned SLOW_DEB_US     = 5000;
   localparam int unsigned FAST_DEB_US     = 500;
   localparam int unsigned SLOW_DEB_CYC    = (CLK_HZ / 1000000) * SLOW_DEB_US;
   localparam int unsigned FAST_DEB_CYC    = (CLK_HZ / 1000000) * FAST_DEB_US;
   localparam int unsigned DEB_W           = 18;
   localparam int unsigned NUM_IN          = 4;

   // input indices
   localparam int unsigned IN_TRIG         = 0;
   localparam int unsigned IN_ENC          = 1;
   localparam int unsigned IN_GEN_A        = 2;
   localparam int unsigned IN_GEN_B        = 3;

   // register byte offsets
   localparam logic [7:0] OFS_PORT_CTRL    = 8'h00;
   localparam logic [7:0] OFS_MD_ADDR      = 8'h04;
   localparam logic [7:0] OFS_IN_CTRL      = 8'h08;
   localparam logic [7:0] OFS_STATUS       = 8'h0C;
   localparam logic [7:0] OFS_ENC_COUNT    = 8'h10;

   // port control field positions
   localparam int unsigned PC_MODE_LSB     = 0;
   localparam int unsigned PC_HS_EN        = 2;
   localparam int unsigned PC_POLLED       = 3;
   localparam int unsigned PC_AUX_EN       = 4;
   localparam int unsigned PC_AUX_ECHO     = 5;
   localparam int unsigned PC_AUX_PASS     = 6;
   localparam int unsigned PC_ONLINE       = 7;

   // input control field positions
   localparam int unsigned IC_POL_LSB      = 0;
   localparam int unsigned IC_SHARED_FAST  = 4;
   localparam int unsigned IC_ENC_SLOW     = 5;
   localparam int unsigned IC_STOP_EN      = 6;

   // reset values
   localparam logic [7:0] PORT_CTRL_RST    = 8'h00;
   localparam logic [7:0] MD_ADDR_RST      = 8'h00;
   localparam logic [6:0] IN_CTRL_RST      = 7'h40;

   typedef enum logic [1:0] {
      SIF_MODE_RS232  = 2'b00,
      SIF_MODE_485_FD = 2'b01,
      SIF_MODE_485_HD = 2'b10
   } sif_mode_t;

   typedef enum logic [1:0] {
      SIF_TX_IDLE = 2'b00,
      SIF_TX_REQ  = 2'b01,
      SIF_TX_SEND = 2'b10
   } sif_tx_state_t;

   // main-port transmit pins grouped
   typedef struct packed {
      logic txd;
      logic rts;
      logic drv_en;
   } sif_main_tx_t;
endpackage : sif_pkg

// ### sim/sif_frontend_bench.sv
`timescale 1ns/10ps
module sif_frontend_bench;
   logic        mclk, resetn, psel, penable, pwrite, msg_pending, msg_txd, poll_seen;
   logic        aux_rxd, aux_core_txd, host_bit, pready, pslverr, msg_grant, main_cts;
   logic        scan_trigger_input, conveyor_encoder_input, generic_input_a, generic_input_b;
   logic        main_rxd, main_txd, main_rts, halfduplex_drv_en, main_rx_to_core, aux_txd;
   logic        aux_rx_to_core, scan_start, phase_end, phase_led, hit;
   logic [7:0]  paddr, poll_addr, cts_delay;
   logic [31:0] pwdata, prdata;
   int          errors, n_tests, n_scan, n_end;

   sif_frontend dut (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .msg_pending, .msg_txd, .poll_seen, .poll_addr, .msg_grant,
      .main_rxd, .main_cts, .main_txd, .main_rts, .halfduplex_drv_en, .main_rx_to_core,
      .aux_rxd, .aux_core_txd, .aux_txd, .aux_rx_to_core, .scan_trigger_input,
      .conveyor_encoder_input, .generic_input_a, .generic_input_b, .scan_start,
      .phase_end, .phase_led);
   sif_host_model host (.mclk, .resetn, .main_rts, .cts_delay, .host_bit, .main_cts, .main_rxd);

   always #12.5 mclk = ~mclk;
   // pulse tallies, sampled at the edge so each one-cycle pulse counts once
   always @(posedge mclk)
   begin
      n_scan += (scan_start === 1'b1);
      n_end += (phase_end === 1'b1);
   end
   //////////////////////////////////////////////////////////////////
   task automatic stop_test;
      if (errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic cyc(int n);
      repeat (n) @(posedge mclk);
   endtask : cyc
   // one apb transfer; entered just after a rising edge
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge mclk);
         i++;
      end
      while (pready !== 1'b1 && i < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so a following call never re-drives psel in this step
      @(posedge mclk);
      if (i >= 50)
      begin
         errors++;
         stop_test();
      end
   endtask : apb
   task automatic wr(logic [7:0] a, logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(string n, logic [7:0] a, logic [31:0] x, logic ex);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(n, q, x);
      chk(n, 32'(e), 32'(ex));
   endtask : rd
   task automatic wait_grant(int lim);
      hit = 1'b0;
      for (int i = 0; i < lim && !hit; i++)
      begin
         @(posedge mclk);
         hit = (msg_grant === 1'b1);
      end
   endtask : wait_grant
   //////////////////////////////////////////////////////////////////
   task automatic t_reset;
      cyc(2);
      chk("rts", 32'(main_rts), 32'h0);
      chk("drv_en", 32'(halfduplex_drv_en), 32'h1);
      rd("port_ctrl", sif_pkg::OFS_PORT_CTRL, 32'h00, 1'b0);
      rd("md_addr", sif_pkg::OFS_MD_ADDR, 32'h00, 1'b0);
      rd("in_ctrl", sif_pkg::OFS_IN_CTRL, 32'h40, 1'b0);
      rd("unmapped", 8'h20, 32'h0, 1'b1);
   endtask : t_reset
   task automatic t_rs232_hs;
      wr(sif_pkg::OFS_PORT_CTRL, 32'h04);
      cts_delay <= 8'h10;
      host_bit <= 1'b0;
      msg_txd <= 1'b0;
      msg_pending <= 1'b1;
      cyc(3);
      chk("rts", 32'(main_rts), 32'h1);
      chk("early grant", 32'(msg_grant), 32'h0);
      wait_grant(60);
      chk("grant", 32'(hit & main_cts), 32'h1);
      cyc(2);
      chk("txd", 32'(main_txd), 32'h0);
      chk("rx core", 32'(main_rx_to_core), 32'h0);
      msg_pending <= 1'b0;
      host_bit <= 1'b1;
      cyc(4);
      chk("rts off", 32'(main_rts | msg_grant), 32'h0);
   endtask : t_rs232_hs
   task automatic t_full_duplex;
      wr(sif_pkg::OFS_PORT_CTRL, 32'h01);
      cts_delay <= 8'hFF;
      msg_pending <= 1'b1;
      wait_grant(10);
      chk("fd grant", 32'(hit), 32'h1);
      chk("fd pins", 32'(halfduplex_drv_en & ~main_rts), 32'h1);
      msg_pending <= 1'b0;
      cyc(4);
   endtask : t_full_duplex
   task automatic t_polled;
      wr(sif_pkg::OFS_MD_ADDR, 32'h5A);
      rd("md_addr", sif_pkg::OFS_MD_ADDR, 32'h5A, 1'b0);
      wr(sif_pkg::OFS_PORT_CTRL, 32'h08);
      msg_pending <= 1'b1;
      wait_grant(30);
      chk("unpolled", 32'(hit | halfduplex_drv_en), 32'h0);
      poll_addr <= 8'hA5;
      poll_seen <= 1'b1;
      wait_grant(10);
      chk("other poll", 32'(hit), 32'h0);
      poll_addr <= 8'h5A;
      wait_grant(10);
      chk("own poll", 32'(hit & halfduplex_drv_en), 32'h1);
      poll_seen <= 1'b0;
      msg_pending <= 1'b0;
      cyc(4);
   endtask : t_polled
   task automatic t_aux;
      wr(sif_pkg::OFS_PORT_CTRL, 32'h00);
      aux_core_txd <= 1'b0;
      aux_rxd <= 1'b0;
      cyc(4);
      chk("aux off", 32'(aux_txd & aux_rx_to_core), 32'h1);
      wr(sif_pkg::OFS_PORT_CTRL, 32'h10);
      cyc(4);
      chk("aux on", 32'(aux_txd | aux_rx_to_core), 32'h0);
      host_bit <= 1'b0;
      wr(sif_pkg::OFS_PORT_CTRL, 32'h30);
      cyc(3);
      chk("aux echo", 32'(aux_txd), 32'h1);
      aux_core_txd <= 1'b1;
      wr(sif_pkg::OFS_PORT_CTRL, 32'h50);
      cyc(3);
      chk("aux pass", 32'(aux_txd), 32'h0);
      host_bit <= 1'b1;
      aux_rxd <= 1'b1;
   endtask : t_aux
   task automatic t_inputs;
      wr(sif_pkg::OFS_PORT_CTRL, 32'h80);
      wr(sif_pkg::OFS_IN_CTRL, 32'h50);
      scan_trigger_input <= 1'b1;
      cyc(100);
      scan_trigger_input <= 1'b0;
      rd("glitch", sif_pkg::OFS_STATUS, 32'h0, 1'b0);
      scan_trigger_input <= 1'b1;
      conveyor_encoder_input <= 1'b1;
      generic_input_b <= 1'b1;
      n_scan = 0;
      n_end = 0;
      cyc(19980);
      chk("scan early", 32'(n_scan), 32'h0);
      cyc(70);
      chk("scan", 32'(n_scan), 32'h1);
      chk("stop", 32'(n_end), 32'h1);
      chk("led on", 32'(phase_led), 32'h1);
      rd("status", sif_pkg::OFS_STATUS, 32'h0B, 1'b0);
      rd("enc", sif_pkg::OFS_ENC_COUNT, 32'h1, 1'b0);
      wr(sif_pkg::OFS_IN_CTRL, 32'h51);
      scan_trigger_input <= 1'b0;
      cyc(20050);
      chk("open scan", 32'(n_scan), 32'h2);
      chk("led off", 32'(phase_led), 32'h0);
   endtask : t_inputs
   //////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      {mclk, resetn, psel, penable, pwrite, msg_pending, poll_seen} = 7'h00;
      {msg_txd, aux_rxd, aux_core_txd, host_bit} = 4'hF;
      {scan_trigger_input, conveyor_encoder_input, generic_input_a, generic_input_b} = 4'h0;
      {paddr, poll_addr, cts_delay, pwdata} = 56'h0;
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_rs232_hs();
      t_full_duplex();
      t_polled();
      t_aux();
      t_inputs();
      stop_test();
   end
endmodule : sif_frontend_bench

// ### sim/sif_frontend_sva.sv
`timescale 1ns/10ps
module sif_frontend_sva
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        resetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // message path
   input wire logic        msg_pending,
   input wire logic        msg_grant,
   input wire logic        main_txd,
   input wire logic        main_rts,
   // inputs and pulses
   input wire logic        scan_trigger_input,
   input wire logic        scan_start,
   input wire logic        phase_end,
   input wire logic        phase_led
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   //////////////////////////////////////////////////////////////////
   // bus answers and serial handshake
   chk_apb_ready: assert property (psel && !penable |=> pready && penable)
      else $error("no ready in access cycle");
   chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("refused access returned data");
   chk_rts_cause: assert property ($rose(main_rts) |-> $past(msg_pending))
      else $error("rts raised with nothing pending");
   chk_grant_pend: assert property (msg_grant |-> $past(msg_pending) || $past(msg_pending, 2))
      else $error("grant without pending message");
   chk_txd_idle: assert property (!msg_grant && !$past(msg_grant) |-> main_txd)
      else $error("txd moved while not granted");
   // pulses last one cycle; lamp follows the filtered current
   chk_scan_pulse: assert property (scan_start |=> !scan_start)
      else $error("scan start longer than one cycle");
   chk_end_pulse: assert property (phase_end |-> !$past(phase_end))
      else $error("phase end longer than one cycle");
   chk_led_level: assert property ($changed(phase_led) |-> phase_led == $past(scan_trigger_input, 3))
      else $error("lamp disagrees with trigger current");
endmodule : sif_frontend_sva

bind sif_frontend sif_frontend_sva u_sva (.mclk, .resetn, .psel, .penable, .prdata, .pready,
   .pslverr, .msg_pending, .msg_grant, .main_txd, .main_rts, .scan_trigger_input,
   .scan_start, .phase_end, .phase_led);

// ### sim/sif_host_model.sv
`timescale 1ns/10ps
module sif_host_model
(
   // clock and reset
   input wire logic       mclk,
   input wire logic       resetn,
   // device side
   input wire logic       main_rts,
   // host behaviour
   input wire logic [7:0] cts_delay,
   input wire logic       host_bit,
   output logic           main_cts,
   output logic           main_rxd
);
   logic [7:0] wait_cnt;
   // cts a set time after rts; dropped at once so a late sender is caught
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         wait_cnt <= 8'h00;
         main_cts <= 1'b0;
      end
      else if (!main_rts)
      begin
         wait_cnt <= 8'h00;
         main_cts <= 1'b0;
      end
      else if (wait_cnt == cts_delay)
         main_cts <= 1'b1;
      else
         wait_cnt <= wait_cnt + 8'h01;
   end
   // host transmit line, idles at mark
   always_ff @(posedge mclk or negedge resetn)
      if (!resetn)
         main_rxd <= 1'b1;
      else
         main_rxd <= host_bit;
endmodule : sif_host_model
